/* dv/tb_top.sv */
// Self-checking bench for the touch converter setup registers.
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  fail_count++; $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module tb_top
  import tcs_pkg::*;
;
  // Short periods keep the run brief; expectations derive from these.
  localparam int FP = 50;
  localparam int LU = 20;
  logic        sys_clk, arst_n, reg_wr, reg_rd, stage_done;
  logic        sample_strobe, irq_request, reg_rdata_valid;
  logic [9:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic        stage_start, stage_cal_active, sequence_done, sample_use;
  logic        converter_active, low_power_active, decimate_by_128;
  logic        drive_output_a_en, drive_output_b_en, irq_pin;
  logic [3:0]  stage_index;
  logic [11:0] stage_select;
  logic [1:0]  converter_bias_boost;
  int          fail_count, n_compared, n_use, n_start, cyc_count;

  tcs_setup_regs #(.FULL_PERIOD_CYC(FP), .LP_UNIT_CYC(LU)) u_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .stage_done(stage_done),
    .sample_strobe(sample_strobe), .stage_start(stage_start),
    .stage_index(stage_index), .stage_select(stage_select),
    .stage_cal_active(stage_cal_active), .sequence_done(sequence_done),
    .sample_use(sample_use), .converter_active(converter_active),
    .low_power_active(low_power_active),
    .decimate_by_128(decimate_by_128),
    .converter_bias_boost(converter_bias_boost),
    .drive_output_a_en(drive_output_a_en),
    .drive_output_b_en(drive_output_b_en),
    .irq_request(irq_request), .irq_pin(irq_pin));

  // Free-running 125 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Event counters and the hang limit, far above the expected run length.
  always @(posedge sys_clk) begin
    cyc_count++;
    if (sample_use === 1'b1) n_use++;
    if (stage_start === 1'b1) n_start++;
    if (cyc_count == 5000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // Inputs move 1 ns after the edge, so the design samples settled values.
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  // A spare cycle after each access keeps strobes from being reassigned.
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    reg_rd = 1'b1;
    reg_addr = a;
    cyc(1);
    reg_rd = 1'b0;
    `CHK(reg_rdata_valid, 1'b1)
    `CHK(reg_rdata, e)
    cyc(1);
  endtask : rd

  task automatic wst(output int n);
    n = 0;
    while (stage_start !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
  endtask : wst

  task automatic t_fields();
    logic [15:0] w;
    rd(OFS_PWR_CTRL, RST_PWR_CTRL);
    rd(OFS_CAL_EN, RST_CAL_EN);
    // Only decimation codes 00 and 01 are ever written here.
    for (int i = 0; i < 4; i++) begin
      w = {i[1:0], i[1:0], 3'h0, i[0], 8'h01};
      wr(OFS_PWR_CTRL, w);
      rd(OFS_PWR_CTRL, w);
      `CHK(converter_bias_boost, i[1:0])
      `CHK(drive_output_a_en, ~i[0])
      `CHK(drive_output_b_en, ~i[1])
      `CHK(decimate_by_128, i[0])
    end
    wr(10'h005, 16'hFFFF);
    rd(10'h005, 16'h0000);
    rd(OFS_PWR_CTRL, w);
    $display("field test done");
  endtask : t_fields

  task automatic t_irq();
    wr(OFS_PWR_CTRL, 16'h0801);
    irq_request = 1'b1;
    cyc(2);
    `CHK(irq_pin, 1'b1)
    wr(OFS_PWR_CTRL, 16'h0001);
    `CHK(irq_pin, 1'b0)
    irq_request = 1'b0;
    cyc(2);
    `CHK(irq_pin, 1'b1)
    $display("interrupt test done");
  endtask : t_irq

  task automatic t_seq();
    int n;
    wr(OFS_CAL_EN, 16'h0005);
    wr(OFS_PWR_CTRL, 16'h0020);
    for (int s = 0; s < 3; s++) begin
      wst(n);
      `CHK(stage_index, s[3:0])
      `CHK(stage_select, 12'h001 << s)
      `CHK(stage_cal_active, s != 1)
      stage_done = 1'b1;
      cyc(1);
      stage_done = 1'b0;
    end
    `CHK(sequence_done, 1'b1)
    wst(n);
    `CHK(n inside {[FP-10:FP+2]}, 1'b1)
    for (int m = 1; m < 4; m += 2) begin
      wr(OFS_PWR_CTRL, {14'h0000, m[1:0]});
      n = n_start;
      cyc(3 * FP);
      `CHK(converter_active, 1'b0)
      `CHK(n_start, n)
    end
    $display("sequence test done");
  endtask : t_seq

  task automatic t_low();
    int n;
    for (int k = 0; k < 4; k += 3) begin
      wr(OFS_PWR_CTRL, 16'h0001);
      wr(OFS_PWR_CTRL, {12'h000, k[1:0], 2'h2});
      `CHK(low_power_active, 1'b1)
      wst(n);
      `CHK(n inside {[(k+1)*LU-3:(k+1)*LU+3]}, 1'b1)
    end
    $display("low power test done");
  endtask : t_low

  // Shutdown first clears the skip count, so the first strobe is used.
  task automatic t_skip(input logic [15:0] cal, input logic [15:0] md,
                        input int e);
    int n;
    wr(OFS_PWR_CTRL, 16'h0001);
    wr(OFS_CAL_EN, cal);
    wr(OFS_PWR_CTRL, md);
    // Samples only count inside a sequence, so wait for one to begin.
    wst(n);
    `CHK(stage_start, 1'b1)
    n_use = 0;
    repeat (16) begin
      sample_strobe = 1'b1;
      cyc(1);
      sample_strobe = 1'b0;
      cyc(1);
    end
    cyc(2);
    `CHK(n_use, e)
    $display("skip test done");
  endtask : t_skip

  task automatic t_reinit();
    wr(OFS_PWR_CTRL, 16'hF802);
    // Calibration is enabled on all twelve stages before the reinit write clears it.
    wr(OFS_CAL_EN, 16'h0FFF);
    wr(OFS_PWR_CTRL, 16'hC401);
    rd(OFS_PWR_CTRL, 16'h0000);
    rd(OFS_CAL_EN, 16'h0000);
    `CHK(low_power_active, 1'b0)
    $display("reinit test done");
  endtask : t_reinit

  // Reset for 16 cycles, then each scenario in turn.
  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 10'h000;
    reg_wdata = 16'h0000;
    stage_done = 1'b0;
    sample_strobe = 1'b0;
    irq_request = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    t_fields();
    t_irq();
    t_seq();
    t_low();
    t_skip(16'h0000, 16'h0000, 4);
    t_skip(16'h1000, 16'h0000, 2);
    t_skip(16'h3000, 16'h0000, 1);
    t_skip(16'h0000, 16'h0002, 16);
    t_skip(16'hC000, 16'h0002, 4);
    t_reinit();
    test_done();
  end
endmodule : tb_top

/* dv/tcs_setup_chk_sva.sv */
// Assertion checker bound to the setup register block.
`timescale 1ns/100ps
module tcs_setup_chk
  import tcs_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        arst_n,
  // Register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [9:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_rdata_valid,
  // Sequencer
  input wire logic        stage_done,
  input wire logic        stage_start,
  input wire logic        sequence_done,
  input wire logic        converter_active,
  // Settings and pins
  input wire logic        low_power_active,
  input wire logic        decimate_by_128,
  input wire logic [1:0]  converter_bias_boost,
  input wire logic        drive_output_a_en,
  input wire logic        drive_output_b_en,
  input wire logic        irq_request,
  input wire logic        irq_pin
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Control word writes; a reinit write keeps none of its own data.
  logic ctl_wr, ini_wr, set_wr;
  assign ctl_wr = reg_wr && reg_addr == OFS_PWR_CTRL;
  assign ini_wr = ctl_wr && reg_wdata[REINIT_BIT];
  assign set_wr = ctl_wr && !reg_wdata[REINIT_BIT];
  // The pin is judged only after a quiet cycle, so no later write blurs it.
  sequence pol_high_s;
    set_wr && reg_wdata[IRQ_POL_BIT] ##1 !reg_wr;
  endsequence
  chk_read_answer: assert property (reg_rd |=> reg_rdata_valid)
    else $error("read not answered");
  chk_valid_cause: assert property (reg_rdata_valid |-> $past(reg_rd))
    else $error("valid without read");
  chk_drive_a: assert property (set_wr |=>
    drive_output_a_en == !$past(reg_wdata[DRV_A_BIT]))
    else $error("first drive enable wrong");
  chk_drive_b: assert property (set_wr |=>
    drive_output_b_en == !$past(reg_wdata[DRV_B_BIT]))
    else $error("second drive enable wrong");
  chk_bias_field: assert property (set_wr |=>
    converter_bias_boost == $past(reg_wdata[BIAS_LSB +: 2]))
    else $error("bias field wrong");
  chk_decim_field: assert property (set_wr |=>
    decimate_by_128 == ($past(reg_wdata[DECIM_LSB +: 2]) == 2'h1))
    else $error("decimation wrong");
  chk_low_mode: assert property (set_wr |=>
    low_power_active == ($past(reg_wdata[MODE_LSB +: 2]) == MODE_LOW))
    else $error("low power flag wrong");
  chk_irq_polarity: assert property (pol_high_s |=>
    irq_pin == $past(irq_request))
    else $error("interrupt pin polarity wrong");
  chk_reinit_clears: assert property (ini_wr |=>
    drive_output_a_en && drive_output_b_en && !low_power_active)
    else $error("reinit left settings");
  chk_shutdown_stop: assert property (set_wr && reg_wdata[MODE_LSB]
    |-> ##[1:2] !converter_active)
    else $error("shutdown did not stop");
  // A write on the edge before may shut the converter down, so skip it.
  chk_stage_step: assert property (stage_done && converter_active
    && !reg_wr && !$past(reg_wr) |=> stage_start || sequence_done)
    else $error("stage did not advance");
endmodule : tcs_setup_chk

bind tcs_setup_regs tcs_setup_chk u_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata_valid(reg_rdata_valid), .stage_done(stage_done),
  .stage_start(stage_start), .sequence_done(sequence_done),
  .converter_active(converter_active),
  .low_power_active(low_power_active), .decimate_by_128(decimate_by_128),
  .converter_bias_boost(converter_bias_boost),
  .drive_output_a_en(drive_output_a_en),
  .drive_output_b_en(drive_output_b_en),
  .irq_request(irq_request), .irq_pin(irq_pin));

/* rtl/tcs_interval_timer.sv */
// Free-running interval timer that pulses once per programmed period.
`timescale 1ns/100ps
module tcs_interval_timer
  import tcs_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // Control
  input  wire logic        run,
  input  wire logic        restart,
  input  wire logic [31:0] period,
  // Event
  output logic             expire
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        fire;
  } tcs_tmr_t;

  tcs_tmr_t st_reg;
  tcs_tmr_t st_next;

  // Count down from the period; a stopped timer holds itself reloaded.
  always_comb begin
    st_next      = st_reg;
    st_next.fire = 1'b0;
    if (!run || restart) begin
      st_next.cnt = period;
    end else if (st_reg.cnt <= 32'h0000_0001) begin
      st_next.cnt  = period;
      st_next.fire = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt - 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign expire = st_reg.fire;

endmodule : tcs_interval_timer

/* rtl/tcs_pkg.sv */
// Constants and carrier types for the touch converter setup registers.
package tcs_pkg;

  // Clock rate and register geometry.
  localparam int unsigned CLK_HZ     = 125_000_000;
  localparam int unsigned ADDR_W     = 10;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned NUM_STAGES = 12;

  // Register offsets and values after reset.
  localparam logic [9:0]  OFS_PWR_CTRL = 10'h000;
  localparam logic [9:0]  OFS_CAL_EN   = 10'h001;
  localparam logic [15:0] RST_PWR_CTRL = 16'h0000;
  localparam logic [15:0] RST_CAL_EN   = 16'h0000;

  // Field positions in the power and sequence control register.
  localparam int unsigned MODE_LSB     = 0;
  localparam int unsigned SLEEP_LSB    = 2;
  localparam int unsigned STAGES_LSB   = 4;
  localparam int unsigned DECIM_LSB    = 8;
  localparam int unsigned REINIT_BIT   = 10;
  localparam int unsigned IRQ_POL_BIT  = 11;
  localparam int unsigned DRV_A_BIT    = 12;
  localparam int unsigned DRV_B_BIT    = 13;
  localparam int unsigned BIAS_LSB     = 14;
  // Field positions in the stage calibration enable register.
  localparam int unsigned FP_SKIP_LSB  = 12;
  localparam int unsigned LP_SKIP_LSB  = 14;

  // Operating state codes and limits.
  localparam logic [1:0] MODE_FULL      = 2'h0;
  localparam logic [1:0] MODE_LOW       = 2'h2;
  localparam logic [3:0] MAX_STAGE_CODE = 4'hB;

  // Sequence timing: times in ms, cycle counts derived from the clock.
  localparam int unsigned FULL_SEQ_MS  = 36;
  localparam int unsigned LP_STEP_MS   = 200;
  localparam int unsigned FULL_SEQ_CYC = CLK_HZ / 1000 * FULL_SEQ_MS;
  localparam int unsigned LP_STEP_CYC  = CLK_HZ / 1000 * LP_STEP_MS;

  // Layout of the power and sequence control register, bit 15 first.
  typedef struct packed {
    logic [1:0] converter_bias_boost;
    logic       drive_output_b_disable;
    logic       drive_output_a_disable;
    logic       irq_polarity_bit;
    logic       software_reinit_bit;
    logic [1:0] decimation_select;
    logic [3:0] stage_count_code;
    logic [1:0] sleep_interval_select;
    logic [1:0] operating_state;
  } tcs_ctrl_t;

  // Layout of the stage calibration enable register, bit 15 first.
  typedef struct packed {
    logic [1:0]  low_power_sample_skip;
    logic [1:0]  full_power_sample_skip;
    logic [11:0] per_stage_calibration_enable;
  } tcs_cal_t;

  // One access from the serial register interface.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [9:0]  addr;
    logic [15:0] wdata;
  } tcs_reg_req_t;

endpackage : tcs_pkg

/* rtl/tcs_sample_skip.sv */
// Decimating gate that passes one sample and then skips a set number.
`timescale 1ns/100ps
module tcs_sample_skip
  import tcs_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Control
  input  wire logic       clear,
  input  wire logic [4:0] skip_n,
  // Samples
  input  wire logic       sample_in,
  output logic            sample_use
);

  typedef struct packed {
    logic [4:0] cnt;
    logic       use_q;
  } tcs_skip_t;

  tcs_skip_t st_reg;
  tcs_skip_t st_next;

  // A zero count accepts the sample and reloads the skip distance.
  always_comb begin
    st_next       = st_reg;
    st_next.use_q = 1'b0;
    if (clear) begin
      st_next.cnt = 5'h00;
    end else if (sample_in) begin
      if (st_reg.cnt == 5'h00) begin
        st_next.use_q = 1'b1;
        st_next.cnt   = skip_n;
      end else begin
        st_next.cnt = st_reg.cnt - 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sample_use = st_reg.use_q;

endmodule : tcs_sample_skip

/* rtl/tcs_setup_regs.sv */
// Setup register pair and conversion sequencer of the touch converter.
//
// Functional notes
// - State 00 runs full power, one conversion sequence about every 36 ms.
// - State codes 01 and 11 mean shutdown; no conversions at all.
// - State 10 is low power; the device wakes by itself to convert.
// - Bits 3:2 pick the low power wait: 200, 400, 600 or 800 ms.
// - Bits 7:4 give stages per sequence minus one; twelve is the most.
// - Bits 9:8 pick decimation: 00 gives 256, 01 gives 128.
// - Writing one to bit 10 clears all registers; the bit self-clears.
// - Bit 11 sets interrupt line polarity: zero low, one high.
// - Bit 12 set to one disables the first excitation output.
// - Bit 13 set to one disables the second excitation output.
// - Bits 15:14 set bias: normal, plus 20, 35 or 50 percent.
// - Calibration bits 0 to 11 enable calibration per stage.
// - Full power skip bits 13:12 skip 3, 7, 15 or 31 samples.
// - Low power skip bits 15:14 skip 0, 1, 2 or 3 samples.
// - Both registers hold zero after reset.
`timescale 1ns/100ps
module tcs_setup_regs
  import tcs_pkg::*;
#(
  parameter int unsigned FULL_PERIOD_CYC = FULL_SEQ_CYC,
  parameter int unsigned LP_UNIT_CYC     = LP_STEP_CYC
)
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // Register access from the serial interface
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [9:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  output logic             reg_rdata_valid,
  // Converter front end, same clock
  input  wire logic        stage_done,
  input  wire logic        sample_strobe,
  output logic             stage_start,
  output logic [3:0]       stage_index,
  output logic [11:0]      stage_select,
  output logic             stage_cal_active,
  output logic             sequence_done,
  output logic             sample_use,
  output logic             converter_active,
  output logic             low_power_active,
  output logic             decimate_by_128,
  output logic [1:0]       converter_bias_boost,
  // Excitation and interrupt pins
  output logic             drive_output_a_en,
  output logic             drive_output_b_en,
  input  wire logic        irq_request,
  output logic             irq_pin
);

  typedef enum logic [1:0] {
    SEQ_OFF,
    SEQ_WAIT,
    SEQ_CONV
  } tcs_seq_t;

  // Every flip-flop outside the wake timer and skip gate sits in this one struct. The read word
  // holds until the next read, so the host may collect it late.
  // mode_seen is last cycle's operating state; a difference from the
  // present one tells the wake timer that the mode has changed, so a
  // new period starts at once.
  typedef struct packed {
    tcs_ctrl_t   ctrl;
    tcs_cal_t    cal;
    logic [15:0] rdata;
    logic        rvalid;
    tcs_seq_t    seq;
    logic [3:0]  stage;
    logic        start;
    logic        done;
    logic [1:0]  mode_seen;
    logic [11:0] sel;
    logic        irq_q;
  } tcs_state_t;

  tcs_state_t   st_reg;
  tcs_state_t   st_next;
  tcs_reg_req_t req;

  logic         mode_run;
  logic         mode_low;
  logic [3:0]   last_stage;
  logic [31:0]  period;
  logic         tick;
  logic [4:0]   skip_n;
  logic [11:0]  sel_next;

  // Bundle the incoming access so decode reads one carrier.
  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  // Decode the operating state; only 00 and 10 run the converter.
  // Both shutdown codes fall out of the same test, so neither needs a case.
  // full power runs
  always_comb begin
    mode_run = (st_reg.ctrl.operating_state == MODE_FULL) ||
               (st_reg.ctrl.operating_state == MODE_LOW);
    mode_low = (st_reg.ctrl.operating_state == MODE_LOW);
  end

  // Pick the wake period; the low power wait is a whole multiple of 200 ms.
  // low power interval
  always_comb begin
    if (mode_low) begin
      period = LP_UNIT_CYC *
               (32'(st_reg.ctrl.sleep_interval_select) + 32'h0000_0001);
    end else begin
      period = FULL_PERIOD_CYC;
    end
  end

  // Clamp the stage count so a code above twelve stages cannot run away.
  // Such codes are illegal, but a stuck sequencer would be worse.
  // stage count clamp
  always_comb begin
    if (st_reg.ctrl.stage_count_code > MAX_STAGE_CODE) begin
      last_stage = MAX_STAGE_CODE;
    end else begin
      last_stage = st_reg.ctrl.stage_count_code;
    end
  end

  // Skip distance depends on the mode the converter is in.
  // Low power codes are the distance itself; full power codes give one
  // less than a power of two, so a small table is cheaper than a shift.
  // full power skip
  always_comb begin
    if (mode_low) begin
      skip_n = {3'h0, st_reg.cal.low_power_sample_skip};
    end else begin
      case (st_reg.cal.full_power_sample_skip)
        2'h0:    skip_n = 5'h03;
        2'h1:    skip_n = 5'h07;
        2'h2:    skip_n = 5'h0F;
        default: skip_n = 5'h1F;
      endcase
    end
  end

  // Wake timer; restarted whenever the mode changes so a new period
  // takes effect at once rather than after a stale one runs out.
  tcs_interval_timer u_timer (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .run     (mode_run),
    .restart (st_reg.mode_seen != st_reg.ctrl.operating_state),
    .period  (period),
    .expire  (tick)
  );

  // Decimating gate on the raw converter samples.
  tcs_sample_skip u_skip (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .clear      (!mode_run),
    .skip_n     (skip_n),
    .sample_in  (sample_strobe && st_reg.seq == SEQ_CONV),
    .sample_use (sample_use)
  );

  // One-hot stage select, one decoder bit per stage.
  // The select is decoded from the next state so that it changes on the
  // same edge as the stage index, never a cycle behind it.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_STAGES; gi++) begin : g_sel
      assign sel_next[gi] = (st_next.seq == SEQ_CONV) &&
                            (st_next.stage == 4'(gi));
    end
  endgenerate

  // Register file, read port and sequencer in one next-state process.
  always_comb begin
    st_next        = st_reg;
    st_next.start  = 1'b0;
    st_next.done   = 1'b0;
    st_next.rvalid = 1'b0;
    st_next.mode_seen = st_reg.ctrl.operating_state;

    // Reads return the stored word one cycle later; holes read zero.
    // The word is copied into its own flip-flops so that it stays put
    // while the host shifts it out, even if a write lands meanwhile.
    if (req.rd) begin
      st_next.rvalid = 1'b1;
      case (req.addr)
        OFS_PWR_CTRL: st_next.rdata = st_reg.ctrl;
        OFS_CAL_EN:   st_next.rdata = st_reg.cal;
        default:      st_next.rdata = 16'h0000;
      endcase
    end

    // Writes land whole; the host keeps decimation to legal codes.
    // decimation stored
    if (req.wr) begin
      case (req.addr)
        OFS_PWR_CTRL: st_next.ctrl = tcs_ctrl_t'(req.wdata);
        OFS_CAL_EN:   st_next.cal  = tcs_cal_t'(req.wdata);
        default:      st_next.cal  = st_reg.cal;
      endcase
    end

    // Sequencer: wait for a wake tick, then walk the stages in order.
    // Stage done pulses are trusted only in the converting state; a stray
    // one while waiting would otherwise skip a stage of the next run.
    // The wake timer keeps running during a sequence.
    case (st_reg.seq)
      SEQ_OFF: begin
        st_next.stage = 4'h0;
        if (mode_run) begin
          st_next.seq = SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        if (tick) begin
          st_next.seq   = SEQ_CONV;
          st_next.stage = 4'h0;
          st_next.start = 1'b1;
        end
      end
      SEQ_CONV: begin
        // A tick during a sequence is dropped; the period is a minimum.
        if (stage_done) begin
          if (st_reg.stage >= last_stage) begin
            st_next.seq   = SEQ_WAIT;
            st_next.stage = 4'h0;
            st_next.done  = 1'b1;
          end else begin
            st_next.stage = st_reg.stage + 4'h1;
            st_next.start = 1'b1;
          end
        end
      end
      default: begin
        st_next.seq = SEQ_OFF;
      end
    endcase

    // Shutdown aborts any sequence in flight.
    // A done pulse from the same edge is dropped, as the run never ended.
    // abort on shutdown
    if (!mode_run) begin
      st_next.seq   = SEQ_OFF;
      st_next.stage = 4'h0;
      st_next.start = 1'b0;
      st_next.done  = 1'b0;
    end

    // Interrupt pin follows the request in the selected sense.
    // It is registered so that a polarity write cannot glitch the pin.
    // interrupt polarity
    st_next.irq_q = st_reg.ctrl.irq_polarity_bit ? irq_request
                                                 : !irq_request;

    // A one in the reinit bit wipes both registers, itself included,
    // and halts the sequencer as a reset would.
    // software reinit
    if (req.wr && req.addr == OFS_PWR_CTRL &&
        req.wdata[REINIT_BIT]) begin
      st_next.ctrl  = tcs_ctrl_t'(RST_PWR_CTRL);
      st_next.cal   = tcs_cal_t'(RST_CAL_EN);
      st_next.done  = 1'b0;
      st_next.seq   = SEQ_OFF;
      st_next.stage = 4'h0;
      st_next.start = 1'b0;
    end
  end

  // Merge the decoded select after the sequencer has settled.
  // A separate copy avoids reading st_next.sel inside the process that
  // writes it, which would be a combinational loop.
  tcs_state_t st_fin;
  always_comb begin
    st_fin     = st_next;
    st_fin.sel = sel_next;
  end

  // State register; all but the interrupt flop clears, the registers read zero after reset.
  // The idle interrupt level is the active-low sense, so it resets high.
  // zero reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg       <= '0;
      st_reg.ctrl  <= tcs_ctrl_t'(RST_PWR_CTRL);
      st_reg.cal   <= tcs_cal_t'(RST_CAL_EN);
      st_reg.irq_q <= 1'b1;
    end else begin
      st_reg <= st_fin;
    end
  end

  // Register read port.
  assign reg_rdata       = st_reg.rdata;
  assign reg_rdata_valid = st_reg.rvalid;

  // Sequencer outputs to the converter front end.
  // All but converter_active and low_power_active come straight from
  // flip-flops, so the front end sees clean levels a whole cycle long.
  assign stage_start      = st_reg.start;
  assign stage_index      = st_reg.stage;
  assign stage_select     = st_reg.sel;
  assign sequence_done    = st_reg.done;
  assign converter_active = (st_reg.seq == SEQ_CONV);
  assign low_power_active = mode_low;

  // Calibration applies only while the enabled stage is converting.
  // per stage calibration
  assign stage_cal_active = |(st_reg.sel &
                              st_reg.cal.per_stage_calibration_enable);

  assign decimate_by_128 = (st_reg.ctrl.decimation_select == 2'h1);

  assign converter_bias_boost = st_reg.ctrl.converter_bias_boost;

  // Excitation outputs are enabled by a zero bit.
  // first excitation gate
  assign drive_output_a_en = !st_reg.ctrl.drive_output_a_disable;
  assign drive_output_b_en = !st_reg.ctrl.drive_output_b_disable;

  assign irq_pin = st_reg.irq_q;

  // Limits a reuser should know.
  // A new low power interval written while already in low power waits
  // for the running interval to expire, since no mode change is seen.
  // Decimation codes 10 and 11 are stored and read back as written, yet
  // the converter treats them as divide by 256; software must avoid them.
  // The skip counter is shared by both power modes and is cleared only
  // in shutdown, so a switch between full and low power keeps whatever
  // skip distance the old mode left behind.
  // Stage count codes above eleven read back as written but run as
  // twelve stages.

endmodule : tcs_setup_regs
